// ### hw/dcf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Width code picks depth and width; 101-111 reserved
// - Port block inputs enable ports while low
// - Read block high holds read data
// - Default write enable low, read enable high
// - Both enable polarities configurable
// - Writes on write clock, reads on read clock
// - Pipeline select low: data same read cycle
// - Pipeline select high: data one cycle later
// - Reset forces read data to zero
// - Reset clears write and read counters
// - Reset: full flags low, empty flags high
// - Only low bits matching width are valid
// - Unused read data bits read as zero
module dcf_fifo
  import dcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic write_port_block_n,
  input wire logic write_en,
  input wire logic [DATA_W-1:0] write_data_bus,
  output logic full_flag,
  output logic almost_full_flag,
  input wire logic read_clk,
  input wire logic read_port_block_n,
  input wire logic read_en,
  output logic [DATA_W-1:0] read_data,
  output logic empty_flag,
  output logic almost_empty_flag
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [LVL_W-1:0] almost_full_lvl_reg;
  logic [LVL_W-1:0] almost_empty_lvl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] rd_mux;
  logic mapped;
  logic apb_wr;
  logic [3:0] status_w;
  logic [2:0] write_width_sel;
  logic [2:0] read_width_sel;
  logic wen_pol;
  logic ren_pol;
  logic read_pipeline_sel;

  assign write_width_sel = ctrl_reg[CTRL_WR_WIDTH_LSB +: 3];
  assign read_width_sel = ctrl_reg[CTRL_RW_LSB +: 3];
  assign wen_pol = ctrl_reg[CTRL_WEN_POL];
  assign ren_pol = ctrl_reg[CTRL_REN_POL];
  assign read_pipeline_sel = ctrl_reg[CTRL_PIPE];

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL: rd_mux[CTRL_W-1:0] = ctrl_reg;
      OFF_STATUS: rd_mux[3:0] = status_w;
      OFF_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
      OFF_ALMOST_FULL_LVL: rd_mux[LVL_W-1:0] = almost_full_lvl_reg;
      OFF_ALMOST_EMPTY_LVL: rd_mux[LVL_W-1:0] = almost_empty_lvl_reg;
      default: mapped = 1'b0;
    endcase
  end

  assign apb_wr = psel && penable && pwrite && mapped && ce;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data is captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      almost_full_lvl_reg <= LVL_RESET;
      almost_empty_lvl_reg <= LVL_RESET;
      irq_mask_reg <= '0;
    end else if (apb_wr) begin
      if (paddr == OFF_CTRL) begin
        ctrl_reg <= pwdata[CTRL_W-1:0];
      end
      if (paddr == OFF_ALMOST_FULL_LVL) begin
        almost_full_lvl_reg <= pwdata[LVL_W-1:0];
      end
      if (paddr == OFF_ALMOST_EMPTY_LVL) begin
        almost_empty_lvl_reg <= pwdata[LVL_W-1:0];
      end
      if (paddr == OFF_IRQ_MASK) begin
        irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (apb_wr && paddr == OFF_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~pwdata[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else if (ce) begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  localparam int TO_R_W = PTR_W + 3 + 3 + 1 + 1 + LVL_W + 1;
  localparam int TO_W_W = PTR_W + 3;

  dcf_xing_if #(.W(TO_R_W)) to_rd ();
  dcf_xing_if #(.W(TO_W_W)) to_wr ();

  logic [PTR_W-1:0] wptr_reg;
  logic [PTR_W-1:0] wptr_next;
  logic [PTR_W-1:0] wgray_reg;
  logic [PTR_W-1:0] rptr_reg;
  logic [PTR_W-1:0] rptr_next;
  logic [PTR_W-1:0] rgray_reg;
  logic rd_refused_tgl_reg;
  logic rd_refused_seen_reg;

  assign to_rd.d = {wgray_reg, write_width_sel, read_width_sel, ren_pol,
                    read_pipeline_sel, almost_empty_lvl_reg, ce};
  assign to_wr.d = {rgray_reg, rd_refused_tgl_reg, empty_flag, almost_empty_flag};

  dcf_sync u_sync_rd (
    .clk(read_clk),
    .rst_n(presetn),
    .x(to_rd)
  );

  dcf_sync u_sync_wr (
    .clk(pclk),
    .rst_n(presetn),
    .x(to_wr)
  );

  // ----------------------------------------------------------------
  // Write domain
  // ----------------------------------------------------------------
  logic mem [0:MEM_BITS-1];
  logic [PTR_W-1:0] rptr_w;
  logic [PTR_W-1:0] used_w;
  logic [PTR_W-1:0] free_w;
  logic [PTR_W-1:0] cap_w;
  logic [ADDR_W-1:0] waddr;
  logic [PTR_W-1:0] wbit;
  logic wr_req;
  logic wr_go;
  logic full_next;
  logic almost_full_next;

  assign rptr_w = gray2bin(to_wr.q[TO_W_W-1 -: PTR_W]);
  assign cap_w = cap_of(write_width_sel);
  assign wr_req = !write_port_block_n && (write_en == wen_pol);
  assign wr_go = ce && wr_req && !full_flag && code_ok(write_width_sel);
  assign wptr_next = wr_go ? ((wptr_reg + 14'h0001) & wrap_of(write_width_sel)) : wptr_reg;
  assign wbit = to_bits(wptr_reg, write_width_sel);
  assign waddr = ADDR_W'((wbit >= cap_w) ? wbit - cap_w : wbit);
  assign used_w = occ(to_bits(wptr_next, write_width_sel),
                      to_bits(rptr_w, read_width_sel), cap_w);
  assign free_w = cap_w - used_w;
  assign full_next = free_w < PTR_W'(width_of(write_width_sel));
  assign almost_full_next = free_w <= to_bits(PTR_W'(almost_full_lvl_reg), write_width_sel);
  assign status_w = {to_wr.q[0], to_wr.q[1], almost_full_flag, full_flag};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      wgray_reg <= '0;
    end else if (ce) begin
      wptr_reg <= wptr_next;
      wgray_reg <= wptr_next ^ (wptr_next >> 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_flag <= 1'b0;
      almost_full_flag <= 1'b0;
    end else if (ce) begin
      full_flag <= full_next;
      almost_full_flag <= almost_full_next;
    end
  end

  // Only the low bits of the selected width are stored
  always_ff @(posedge pclk) begin
    if (wr_go) begin
      for (int i = 0; i < DATA_W; i++) begin
        if (5'(i) < width_of(write_width_sel)) begin
          mem[int'(waddr) + i] <= write_data_bus[i];
        end
      end
    end
  end

  // Event collection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_refused_seen_reg <= 1'b0;
    end else if (ce) begin
      rd_refused_seen_reg <= to_wr.q[2];
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_WR_REFUSED] = ce && wr_req && (full_flag || !code_ok(write_width_sel));
    irq_set[IRQ_RD_REFUSED] = ce && (to_wr.q[2] != rd_refused_seen_reg);
    irq_set[IRQ_FULL] = ce && full_next && !full_flag;
  end

  // ----------------------------------------------------------------
  // Read domain
  // ----------------------------------------------------------------
  logic [PTR_W-1:0] wptr_r;
  logic [2:0] wr_width_r;
  logic [2:0] rw_r;
  logic ren_pol_r;
  logic pipe_r;
  logic [LVL_W-1:0] almost_empty_lvl_r;
  logic ce_r;
  logic [PTR_W-1:0] used_r;
  logic [PTR_W-1:0] cap_r;
  logic [PTR_W-1:0] rbit;
  logic [ADDR_W-1:0] raddr;
  logic rd_req;
  logic rd_go;
  logic empty_next;
  logic almost_empty_next;
  logic [DATA_W-1:0] rd_raw;
  logic [DATA_W-1:0] stage_reg;

  assign {wptr_r, wr_width_r, rw_r, ren_pol_r, pipe_r, almost_empty_lvl_r, ce_r} =
    {gray2bin(to_rd.q[TO_R_W-1 -: PTR_W]), to_rd.q[TO_R_W-PTR_W-1:0]};
  assign cap_r = cap_of(wr_width_r);
  assign rd_req = !read_port_block_n && (read_en == ren_pol_r);
  assign rd_go = ce_r && rd_req && !empty_flag && code_ok(rw_r);
  assign rptr_next = rd_go ? ((rptr_reg + 14'h0001) & wrap_of(rw_r)) : rptr_reg;
  assign rbit = to_bits(rptr_reg, rw_r);
  assign raddr = ADDR_W'((rbit >= cap_r) ? rbit - cap_r : rbit);
  assign used_r = occ(to_bits(wptr_r, wr_width_r), to_bits(rptr_next, rw_r), cap_r);
  assign empty_next = used_r < PTR_W'(width_of(rw_r));
  assign almost_empty_next = used_r <= to_bits(PTR_W'(almost_empty_lvl_r), rw_r);

  // Bits above the read width come out as zero
  always_comb begin
    rd_raw = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (5'(i) < width_of(rw_r)) begin
        rd_raw[i] = mem[int'(raddr) + i];
      end
    end
  end

  always_ff @(posedge read_clk or negedge presetn) begin
    if (!presetn) begin
      rptr_reg <= '0;
      rgray_reg <= '0;
      rd_refused_tgl_reg <= 1'b0;
    end else if (ce_r) begin
      rptr_reg <= rptr_next;
      rgray_reg <= rptr_next ^ (rptr_next >> 1);
      if (rd_req && (empty_flag || !code_ok(rw_r))) begin
        rd_refused_tgl_reg <= !rd_refused_tgl_reg;
      end
    end
  end

  always_ff @(posedge read_clk or negedge presetn) begin
    if (!presetn) begin
      empty_flag <= 1'b1;
      almost_empty_flag <= 1'b1;
    end else if (ce_r) begin
      empty_flag <= empty_next;
      almost_empty_flag <= almost_empty_next;
    end
  end

  always_ff @(posedge read_clk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= '0;
      read_data <= '0;
    end else if (ce_r && !read_port_block_n) begin
      if (rd_go) begin
        stage_reg <= rd_raw;
      end
      if (pipe_r) begin
        read_data <= stage_reg;
      end else if (rd_go) begin
        read_data <= rd_raw;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_full_blocks_wr: assert property (@(posedge pclk) disable iff (!presetn)
    full_flag && wr_req |=> wptr_reg == $past(wptr_reg))
    else $error("write taken while full");

  chk_blocked_wr: assert property (@(posedge pclk) disable iff (!presetn)
    write_port_block_n |=> $stable(wptr_reg))
    else $error("write taken while port blocked");

  chk_wen_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    (write_en != wen_pol) |=> $stable(wptr_reg))
    else $error("write taken with enable inactive");

  chk_reserved_code: assert property (@(posedge pclk) disable iff (!presetn)
    !code_ok(write_width_sel) |=> $stable(wptr_reg))
    else $error("write taken with reserved width code");

  chk_wr_reset_flags: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !full_flag && !almost_full_flag && wptr_reg == 14'h0000)
    else $error("write flags or counter wrong after reset");

  chk_rd_reset_out: assert property (@(posedge read_clk) disable iff (!presetn)
    $rose(presetn) |-> read_data == '0 && empty_flag && almost_empty_flag)
    else $error("read side not cleared by reset");

  chk_empty_blocks_rd: assert property (@(posedge read_clk) disable iff (!presetn)
    empty_flag ##0 rd_req |=> $stable(rptr_reg))
    else $error("read taken while empty");

  chk_block_hold: assert property (@(posedge read_clk) disable iff (!presetn)
    read_port_block_n |=> $stable(read_data))
    else $error("read data moved while port blocked");

  chk_flow_through: assert property (@(posedge read_clk) disable iff (!presetn)
    rd_go && !pipe_r |=> read_data == $past(rd_raw))
    else $error("unpipelined read data late");

  chk_pipe_delay: assert property (@(posedge read_clk) disable iff (!presetn)
    rd_go && pipe_r ##1 (ce_r && !read_port_block_n && pipe_r)
      |=> read_data == $past(rd_raw, 2))
    else $error("pipelined read data not one cycle later");

endmodule
`default_nettype wire

// ### hw/dcf_pkg.sv
`default_nettype none
package dcf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int PTR_W = 14;
  localparam int ADDR_W = 13;
  localparam int MEM_BITS = 4608;
  localparam logic [PTR_W-1:0] CAP_NARROW = 14'h1000;
  localparam logic [PTR_W-1:0] CAP_WIDE = 14'h1200;

  // Width select codes
  localparam logic [2:0] WSEL_X1 = 3'h0;
  localparam logic [2:0] WSEL_X2 = 3'h1;
  localparam logic [2:0] WSEL_X4 = 3'h2;
  localparam logic [2:0] WSEL_X9 = 3'h3;
  localparam logic [2:0] WSEL_X18 = 3'h4;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_ALMOST_FULL_LVL = 8'h10;
  localparam logic [7:0] OFF_ALMOST_EMPTY_LVL = 8'h14;

  localparam int CTRL_W = 9;
  localparam int CTRL_WR_WIDTH_LSB = 0;
  localparam int CTRL_RW_LSB = 3;
  localparam int CTRL_WEN_POL = 6;
  localparam int CTRL_REN_POL = 7;
  localparam int CTRL_PIPE = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h080;

  localparam int ST_FULL = 0;
  localparam int ST_ALMOST_FULL = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_ALMOST_EMPTY = 3;

  localparam int IRQ_W = 3;
  localparam int IRQ_WR_REFUSED = 0;
  localparam int IRQ_RD_REFUSED = 1;
  localparam int IRQ_FULL = 2;

  localparam int LVL_W = 13;
  localparam logic [LVL_W-1:0] LVL_RESET = 13'h0004;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic code_ok(input logic [2:0] c);
    return c <= WSEL_X18;
  endfunction

  function automatic logic [4:0] width_of(input logic [2:0] c);
    case (c)
      WSEL_X1: return 5'h01;
      WSEL_X2: return 5'h02;
      WSEL_X4: return 5'h04;
      WSEL_X9: return 5'h09;
      default: return 5'h12;
    endcase
  endfunction

  // Pointer wraps at twice the port depth
  function automatic logic [PTR_W-1:0] wrap_of(input logic [2:0] c);
    case (c)
      WSEL_X1: return 14'h1fff;
      WSEL_X2: return 14'h0fff;
      WSEL_X4: return 14'h07ff;
      WSEL_X9: return 14'h03ff;
      default: return 14'h01ff;
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] cap_of(input logic [2:0] c);
    return (c >= WSEL_X9) ? CAP_WIDE : CAP_NARROW;
  endfunction

  function automatic logic [PTR_W-1:0] to_bits(input logic [PTR_W-1:0] p,
                                                input logic [2:0] c);
    return PTR_W'(p * PTR_W'(width_of(c)));
  endfunction

  function automatic logic [PTR_W-1:0] occ(input logic [PTR_W-1:0] a,
                                            input logic [PTR_W-1:0] b,
                                            input logic [PTR_W-1:0] cap);
    return (a >= b) ? a - b : a - b + PTR_W'(cap << 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage
`default_nettype wire

// ### hw/dcf_xing_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcf_xing_if #(parameter int W = 1);
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport src (output d, input q);
  modport sync (input d, output q);
endinterface
`default_nettype wire

// ### hw/dcf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_sync (
  input wire logic clk,
  input wire logic rst_n,
  dcf_xing_if.sync x
);
  localparam int W = $bits(x.d);

  logic [W-1:0] meta_reg;
  logic [W-1:0] stab_reg;

  // ----------------------------------------------------------------
  // Two-flop crossing; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      stab_reg <= '0;
    end else begin
      meta_reg <= x.d;
      stab_reg <= meta_reg;
    end
  end

  assign x.q = stab_reg;
endmodule
`default_nettype wire

// ### testbench/dcf_user_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_user_model
  import dcf_pkg::*;
(
  input wire logic clk,
  output logic write_port_block_n,
  output logic write_en,
  output logic [DATA_W-1:0] write_data_bus,
  output logic read_port_block_n,
  output logic read_en,
  input wire logic [DATA_W-1:0] read_data
);
  logic wpol;
  logic rpol;

  initial begin
    wpol = 1'b0;
    rpol = 1'b1;
    write_port_block_n = 1'b1;
    write_en = 1'b1;
    write_data_bus = 18'h2aaaa;
    read_port_block_n = 1'b1;
    read_en = 1'b0;
  end

  // One word per call; unused upper bits always grounded, low bits inverted when idle
  task automatic push(input logic [DATA_W-1:0] d, input logic [4:0] w, input logic blk);
    logic [DATA_W-1:0] m;
    m = (18'h00001 << w) - 18'h00001;
    @(posedge clk);
    write_port_block_n <= blk;
    write_en <= wpol;
    write_data_bus <= d & m;
    @(posedge clk);
    write_port_block_n <= 1'b1;
    write_en <= ~wpol;
    write_data_bus <= ~d & m;
  endtask

  // Early is sampled after the taking edge, d once the data is due
  task automatic pop(input logic pipe, input logic blk, output logic [DATA_W-1:0] early,
                     output logic [DATA_W-1:0] d);
    @(posedge clk);
    read_port_block_n <= blk;
    read_en <= rpol;
    @(posedge clk);
    read_en <= ~rpol;
    if (!pipe) begin
      read_port_block_n <= 1'b1;
    end
    @(negedge clk);
    early = read_data;
    if (pipe) begin
      @(posedge clk);
      read_port_block_n <= 1'b1;
      @(negedge clk);
    end
    d = read_data;
  endtask
endmodule
`default_nettype wire

// ### testbench/dcf_fifo_test.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_test;
  import dcf_pkg::*;
  localparam logic [4:0] WID [5] = '{5'h01, 5'h02, 5'h04, 5'h09, 5'h12};
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, err;
  logic full_flag, almost_full_flag, empty_flag, almost_empty_flag;
  logic write_port_block_n, write_en, read_port_block_n, read_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] write_data_bus, read_data, early, got, m;
  int n_mismatch = 0;
  int n_compared = 0;

  dcf_fifo u_dcf_fifo (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .write_port_block_n(write_port_block_n),
    .write_en(write_en), .write_data_bus(write_data_bus), .full_flag(full_flag),
    .almost_full_flag(almost_full_flag), .read_clk(pclk),
    .read_port_block_n(read_port_block_n), .read_en(read_en), .read_data(read_data),
    .empty_flag(empty_flag), .almost_empty_flag(almost_empty_flag));

  dcf_user_model u_model (
    .clk(pclk), .write_port_block_n(write_port_block_n), .write_en(write_en),
    .write_data_bus(write_data_bus), .read_port_block_n(read_port_block_n),
    .read_en(read_en), .read_data(read_data));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wval);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wval;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(name, exp, rd);
  endtask

  task automatic cfg(input logic [31:0] v);
    apb(1'b1, OFF_CTRL, v);
    repeat (4) @(posedge pclk);
  endtask

  task automatic xfer(input logic [DATA_W-1:0] d, input logic pipe);
    u_model.push(d, 5'h12, 1'b0);
    repeat (5) @(posedge pclk);
    u_model.pop(pipe, 1'b0, early, got);
  endtask

  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (8) @(posedge pclk);
    check("rst_read_data", 32'h0, 32'(read_data));
    check("rst_flags", 32'h3,
          32'({full_flag, almost_full_flag, empty_flag, almost_empty_flag}));
    check("rst_irq", 32'h0, 32'(irq));
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk("ctrl_reset", OFF_CTRL, 32'(CTRL_RESET));
    rchk("almost_full_lvl_reset", OFF_ALMOST_FULL_LVL, 32'(LVL_RESET));
    rchk("unmapped_data", 8'h40, 32'h0);
    check("unmapped_err", 32'h1, 32'(err));
    $display("test reset done");
    for (int c = 0; c < 5; c++) begin
      m = (18'h00001 << WID[c]) - 18'h00001;
      cfg(32'h080 | 32'(c) | (32'(c) << 3));
      u_model.push(18'h3a5c3 ^ 18'(c), WID[c], 1'b0);
      repeat (5) @(posedge pclk);
      u_model.pop(1'b0, 1'b0, early, got);
      check("width_data", 32'((18'h3a5c3 ^ 18'(c)) & m), 32'(got & m));
    end
    $display("test widths done");
    cfg(32'h1a4);
    xfer(18'h1b2c3, 1'b1);
    check("pipe_early", 32'h3a5c7, 32'(early));
    check("pipe_data", 32'h1b2c3, 32'(got));
    cfg(32'h0a4);
    u_model.push(18'h0f0f0, 5'h12, 1'b0);
    repeat (5) @(posedge pclk);
    u_model.pop(1'b0, 1'b1, early, got);
    check("blocked_hold", 32'h1b2c3, 32'(got));
    check("blocked_kept", 32'h0, 32'(empty_flag));
    u_model.pop(1'b0, 1'b0, early, got);
    check("after_block", 32'h0f0f0, 32'(got));
    u_model.push(18'h00aa5, 5'h12, 1'b1);
    repeat (5) @(posedge pclk);
    check("write_blocked", 32'h1, 32'(empty_flag));
    u_model.wpol = 1'b1;
    u_model.rpol = 1'b0;
    cfg(32'h064);
    xfer(18'h2468a, 1'b0);
    check("polarity_data", 32'h2468a, 32'(got));
    u_model.wpol = 1'b0;
    u_model.rpol = 1'b1;
    cfg(32'h0a4);
    $display("test port controls done");
    apb(1'b1, OFF_IRQ_MASK, 32'h7);
    u_model.pop(1'b0, 1'b0, early, got);
    repeat (6) @(posedge pclk);
    check("empty_read_held", 32'h2468a, 32'(got));
    rchk("stat_rd_refused", OFF_IRQ_STAT, 32'h2);
    check("irq_on", 32'h1, 32'(irq));
    apb(1'b1, OFF_IRQ_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq_cleared", 32'h0, 32'(irq));
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    u_model.pop(1'b0, 1'b0, early, got);
    repeat (6) @(posedge pclk);
    check("irq_masked", 32'h0, 32'(irq));
    apb(1'b1, OFF_IRQ_STAT, 32'h7);
    cfg(32'h0a5);
    u_model.push(18'h01234, 5'h12, 1'b0);
    repeat (6) @(posedge pclk);
    rchk("stat_reserved", OFF_IRQ_STAT, 32'h1);
    check("reserved_empty", 32'h1, 32'(empty_flag));
    apb(1'b1, OFF_IRQ_STAT, 32'h7);
    $display("test refusals done");
    cfg(32'h0a4);
    for (int i = 0; i < 256; i++) u_model.push(18'(i), 5'h12, 1'b0);
    repeat (2) @(posedge pclk);
    check("full_flags", 32'h3, 32'({full_flag, almost_full_flag}));
    u_model.push(18'h3ffff, 5'h12, 1'b0);
    repeat (6) @(posedge pclk);
    rchk("stat_full", OFF_IRQ_STAT, 32'h5);
    for (int i = 0; i < 256; i++) begin
      u_model.pop(1'b0, 1'b0, early, got);
      check("drain", 32'(i), 32'(got));
    end
    repeat (5) @(posedge pclk);
    check("drained_empty", 32'h1, 32'(empty_flag));
    $display("test full done");
    ce <= 1'b0;
    apb(1'b1, OFF_IRQ_MASK, 32'h7);
    u_model.push(18'h00777, 5'h12, 1'b0);
    repeat (5) @(posedge pclk);
    check("frozen_empty", 32'h1, 32'(empty_flag));
    ce <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk("frozen_mask", OFF_IRQ_MASK, 32'h0);
    $display("test clock enable done");
    u_model.push(18'h12345, 5'h12, 1'b0);
    u_model.push(18'h2abcd, 5'h12, 1'b0);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    check("rerst_data", 32'h0, 32'(read_data));
    check("rerst_flags", 32'h3,
          32'({full_flag, almost_full_flag, empty_flag, almost_empty_flag}));
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk("ctrl_rereset", OFF_CTRL, 32'(CTRL_RESET));
    cfg(32'h0a4);
    xfer(18'h00155, 1'b0);
    check("counters_cleared", 32'h00155, 32'(got));
    $display("test reset mid-run done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
